// [common/spc_pkg.sv]
// spc_pkg: constants, register map and carrier types of the stepper
// phase and chopper logic.
// assumes a 200 MHz pclk; every time below becomes a cycle count from it.
package spc_pkg;

   // ==========================================================
   // clock and timing
   // ==========================================================
   localparam int CLK_MHZ        = 200;   // pclk rate
   localparam int DEAD_NS        = 1000;  // leg dead time, least
   localparam int BLANK_NS       = 1000;  // comparator blanking, least
   localparam int MIN_ON_NS      = 2500;  // least on time of a bridge
   // least times round up to whole cycles
   localparam int DEAD_CYC       = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int BLANK_CYC      = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int MIN_ON_CYC     = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W          = 10;    // holds the counts above
   localparam int OFF_W          = 21;    // off-time counter width (up to 10.49 ms)
   localparam logic [OFF_W-1:0] OFFTIME_RST = 21'h000a28; // 13 us

   // ==========================================================
   // register map (byte addresses)
   // ==========================================================
   localparam logic [7:0] ADDR_STATUS    = 8'h00;
   localparam logic [7:0] ADDR_OFFTIME_A = 8'h04;
   localparam logic [7:0] ADDR_OFFTIME_B = 8'h08;
   localparam logic [7:0] ADDR_INT_STAT  = 8'h0c;
   localparam logic [7:0] ADDR_INT_MASK  = 8'h10;

   // interrupt bit positions
   localparam int INT_STEP  = 0;
   localparam int INT_TRIPA = 1;
   localparam int INT_TRIPB = 2;
   localparam int INT_OVC   = 3;
   localparam int INT_THERM = 4;
   localparam int INT_UVLO  = 5;
   localparam int INT_W     = 6;

   // status field positions
   localparam int ST_PHASE  = 0;   // 3 bits, home state reads 0
   localparam int ST_GATE_A = 4;   // 4 bits
   localparam int ST_GATE_B = 8;   // 4 bits
   localparam int ST_FAULT  = 12;  // protection pulling enable low
   localparam int ST_EN     = 13;  // bridges enabled

   // ==========================================================
   // sequencer
   // ==========================================================
   localparam logic [2:0] PHASE_HOME = 3'h0;  // state 1
   // drive polarity: 00 off, 01 positive, 10 negative; 2 bits per state
   localparam logic [15:0] POL_TAB_A = 16'h4a85; // +,+,0,-,-,-,0,+
   localparam logic [15:0] POL_TAB_B = 16'ha854; // 0,+,+,+,0,-,-,-

   typedef enum logic [1:0] {
      SPC_POL_OFF = 2'b00,
      SPC_POL_POS = 2'b01,
      SPC_POL_NEG = 2'b10
   } spc_pol_t;

   // gate drive of one full bridge
   typedef struct packed {
      logic hi1;
      logic lo1;
      logic hi2;
      logic lo2;
   } spc_gate_t;

   // logic-level pins from the host
   typedef struct packed {
      logic step_clk;
      logic rotation_dir;
      logic half_step;
      logic slow_decay;
      logic reset_n;
      logic enable;
   } spc_pins_t;

endpackage : spc_pkg

// [hdl/spc_chop.sv]
// spc_chop: constant off-time chopper of one full bridge.
// assumes trip is already synchronised and pol comes from the sequencer.
`timescale 1ns/1ps
module spc_chop
   import spc_pkg::*;
#(
   parameter int OW = OFF_W
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            bridge_en,
   input  wire logic            slow_decay,
   input  wire spc_pkg::spc_pol_t pol,
   input  wire logic            trip,
   input  wire logic [OW-1:0]   offtime,
   output spc_pkg::spc_gate_t   gate,
   output logic                 trip_evt
);

   // ==========================================================
   // state
   // ==========================================================
   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,   // everything off
      CH_DEAD = 2'b01,   // dead time before turn-on
      CH_ON   = 2'b10,   // conducting
      CH_OFF  = 2'b11    // monostable running
   } spc_ch_t;

   spc_ch_t          st_r;     // chopper state
   logic [OW-1:0]    cnt_r;    // shared timer
   spc_pol_t         pol_r;    // polarity being driven
   spc_gate_t        gate_nxt; // next gate drive
   logic             keep_hi_r; // dead time entered from an off time

   logic trip_ok;
   // blanking and least on time both gate the comparator
   assign trip_ok = (cnt_r >= OW'(BLANK_CYC)) && (cnt_r >= OW'(MIN_ON_CYC));

   // ==========================================================
   // state machine
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r     <= CH_IDLE;
         cnt_r    <= '0;
         pol_r    <= SPC_POL_OFF;
         trip_evt <= 1'b0;
         keep_hi_r <= 1'b0;
      end else begin
         trip_evt <= 1'b0;
         if (!bridge_en || pol == SPC_POL_OFF) begin
            st_r  <= CH_IDLE;
            cnt_r <= '0;
            pol_r <= SPC_POL_OFF;
            keep_hi_r <= 1'b0;
         end else if (pol != pol_r) begin
            st_r  <= CH_DEAD;
            cnt_r <= '0;
            pol_r <= pol;
            keep_hi_r <= 1'b0;
         end else begin
            unique case (st_r)
               CH_IDLE: begin
                  st_r  <= CH_DEAD;
                  cnt_r <= '0;
                  keep_hi_r <= 1'b0;
               end
               CH_DEAD: begin
                  if (cnt_r >= OW'(DEAD_CYC - 1)) begin
                     st_r  <= CH_ON;
                     cnt_r <= '0;
                  end else begin
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
               CH_ON: begin
                  if (trip && trip_ok) begin
                     st_r     <= CH_OFF;
                     cnt_r    <= '0;
                     trip_evt <= 1'b1;
                  end else if (!trip_ok) begin
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
               CH_OFF: begin
                  if (cnt_r + 1'b1 >= offtime) begin
                     st_r  <= CH_DEAD;
                     keep_hi_r <= 1'b1;
                     cnt_r <= '0;
                  end else begin
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // ==========================================================
   // gate decode
   // ==========================================================
   always_comb begin
      gate_nxt = '0;
      if (st_r == CH_ON) begin
         // positive: hi1 + lo2, negative: hi2 + lo1
         gate_nxt.hi1 = (pol_r == SPC_POL_POS);
         gate_nxt.lo2 = (pol_r == SPC_POL_POS);
         gate_nxt.hi2 = (pol_r == SPC_POL_NEG);
         gate_nxt.lo1 = (pol_r == SPC_POL_NEG);
      // after a polarity change every switch stays off, so the other leg gets its dead time
      end else if (st_r == CH_OFF || (st_r == CH_DEAD && slow_decay && keep_hi_r)) begin
         // slow decay keeps high side on
         if (slow_decay) begin
            gate_nxt.hi1 = (pol_r == SPC_POL_POS);
            gate_nxt.hi2 = (pol_r == SPC_POL_NEG);
         end
      end
   end

   // gates are registered; re-checked against enable for a fast off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate <= '0;
      end else begin
         gate <= bridge_en ? gate_nxt : '0;
      end
   end

endmodule : spc_chop

// [hdl/spc_sync.sv]
// spc_sync: two-flop synchroniser for a vector of levels.
// assumes each bit is an independent level from outside pclk.
`timescale 1ns/1ps
module spc_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // ==========================================================
   // two stages
   // ==========================================================
   logic [W-1:0] meta_r;  // first stage, read only by the second

   // the first flop may go metastable; only q is used downstream
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : spc_sync

// [hdl/spc_top.sv]
// spc_top: phase sequencer, two choppers, protection and APB registers
// of a two-phase bipolar stepper driver.
// assumes host pins and analogue comparator flags arrive unsynchronised;
// APB master runs on pclk.
`timescale 1ns/1ps

// Functional notes
// - one step per rising step clock edge
// - direction high clockwise, low reverse
// - step select high half, low full
// - reset pin low holds home state one
// - decay pin high slow, low fast
// - enable low turns every switch off
// - overcurrent or thermal pulls enable low
// - two independent off-time choppers
// - each bridge has its own off time
// - comparator blanked one microsecond after turn-on
// - trip turns bridge off until timeout
// - fast decay both off, slow one
// - dead time between leg transistors
// - least on time before a trip
module spc_top
   import spc_pkg::*;
#(
   parameter int OW = OFF_W
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // host logic pins
   input  wire spc_pkg::spc_pins_t  pins,
   // open-drain enable pin: driven low by protection
   output logic                     enable_o,
   output logic                     enable_oe_n,
   // analogue flags
   input  wire logic                sense_trip_a,
   input  wire logic                sense_trip_b,
   input  wire logic                overcurrent_limit,
   input  wire logic                thermal_fault,
   input  wire logic                undervoltage,
   // bridge gates
   output spc_pkg::spc_gate_t       gate_a,
   output spc_pkg::spc_gate_t       gate_b,
   output logic                     irq
);

   // ==========================================================
   // helpers
   // ==========================================================
   // polarity of one bridge in one half-step state
   function automatic spc_pol_t spc_pol_of(input logic [15:0] tab,
                                           input logic [2:0]  idx);
      logic [1:0] v;
      v = tab[{idx, 1'b0} +: 2];
      return spc_pol_t'(v);
   endfunction : spc_pol_of

   // ==========================================================
   // input synchronisers
   // ==========================================================
   spc_pins_t pins_s;        // synchronised host pins
   logic [4:0] ana_s;        // synchronised analogue flags

   spc_sync #(.W($bits(spc_pins_t))) u_sync_pins (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (pins),
      .q       (pins_s)
   );

   spc_sync #(.W(5)) u_sync_ana (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({sense_trip_a, sense_trip_b, overcurrent_limit,
                 thermal_fault, undervoltage}),
      .q       (ana_s)
   );

   logic trip_a_s;      // bridge a comparator
   logic trip_b_s;      // bridge b comparator
   logic ovc_s;         // supply overcurrent
   logic therm_s;       // thermal shutdown
   logic uvlo_s;        // undervoltage lockout
   assign {trip_a_s, trip_b_s, ovc_s, therm_s, uvlo_s} = ana_s;

   // ==========================================================
   // step clock edge detection
   // ==========================================================
   logic step_d_r;      // previous synchronised step level
   logic step_rise;     // one-cycle pulse on rising edge

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_d_r <= 1'b0;
      end else begin
         step_d_r <= pins_s.step_clk;
      end
   end

   assign step_rise = pins_s.step_clk && !step_d_r;

   // ==========================================================
   // phase sequencer
   // ==========================================================
   logic [2:0] phase_r;   // half-step state, 0 is home state 1
   logic [2:0] stride;    // 1 in half step, 2 in full step

   assign stride = pins_s.half_step ? 3'h1 : 3'h2;

   // a low reset pin wins over a simultaneous step edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= PHASE_HOME;
      end else if (!pins_s.reset_n) begin
         phase_r <= PHASE_HOME;
      end else if (step_rise) begin
         if (pins_s.rotation_dir) begin
            phase_r <= phase_r + stride;
         end else begin
            phase_r <= phase_r - stride;
         end
      end
   end

   spc_pol_t pol_a;   // drive polarity of bridge a
   spc_pol_t pol_b;   // drive polarity of bridge b
   assign pol_a = spc_pol_of(POL_TAB_A, phase_r);
   assign pol_b = spc_pol_of(POL_TAB_B, phase_r);

   // ==========================================================
   // protection
   // ==========================================================
   logic fault_r;     // protection pulls enable pin low
   logic bridge_en;   // both bridges may switch

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_r <= 1'b0;
      end else begin
         fault_r <= ovc_s || therm_s;
      end
   end

   // open drain: only ever drives low, released otherwise
   assign enable_o    = 1'b0;
   assign enable_oe_n = !fault_r;

   // the pin reads low while we pull it, but that loops back two
   // cycles late, so the internal fault is also folded in directly
   // master enable
   assign bridge_en = pins_s.enable && !fault_r && !uvlo_s && !therm_s;

   // ==========================================================
   // choppers
   // ==========================================================
   logic [OW-1:0] offtime_net_a_r;  // bridge a off time, cycles
   logic [OW-1:0] offtime_net_b_r;  // bridge b off time, cycles
   logic          tripev_a;         // bridge a monostable fired
   logic          tripev_b;         // bridge b monostable fired

   spc_chop #(.OW(OW)) u_chop_a (
      .pclk       (pclk),
      .presetn    (presetn),
      .bridge_en  (bridge_en),
      .slow_decay (pins_s.slow_decay),
      .pol        (pol_a),
      .trip       (trip_a_s),
      .offtime    (offtime_net_a_r),
      .gate       (gate_a),
      .trip_evt   (tripev_a)
   );

   spc_chop #(.OW(OW)) u_chop_b (
      .pclk       (pclk),
      .presetn    (presetn),
      .bridge_en  (bridge_en),
      .slow_decay (pins_s.slow_decay),
      .pol        (pol_b),
      .trip       (trip_b_s),
      .offtime    (offtime_net_b_r),
      .gate       (gate_b),
      .trip_evt   (tripev_b)
   );

   // ==========================================================
   // apb decode
   // ==========================================================
   logic wr_acc;            // write access phase
   logic rd_setup;          // setup phase of any transfer, read or write
   logic addr_ok;           // mapped address

   assign pready   = 1'b1;  // zero wait states
   assign wr_acc   = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign addr_ok  = (paddr == ADDR_STATUS) || (paddr == ADDR_OFFTIME_A) ||
                     (paddr == ADDR_OFFTIME_B) || (paddr == ADDR_INT_STAT) ||
                     (paddr == ADDR_INT_MASK);

   // ==========================================================
   // off-time registers
   // ==========================================================
   // separate off times
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offtime_net_a_r <= OW'(OFFTIME_RST);
         offtime_net_b_r <= OW'(OFFTIME_RST);
      end else if (wr_acc) begin
         if (paddr == ADDR_OFFTIME_A) begin
            offtime_net_a_r <= pwdata[OW-1:0];
         end
         if (paddr == ADDR_OFFTIME_B) begin
            offtime_net_b_r <= pwdata[OW-1:0];
         end
      end
   end

   // ==========================================================
   // interrupts
   // ==========================================================
   logic [INT_W-1:0] int_stat_r;  // sticky events
   logic [INT_W-1:0] int_mask_r;  // 1 enables the event
   logic [INT_W-1:0] int_set;     // events this cycle
   logic [INT_W-1:0] int_clr;     // write-one-to-clear
   logic             ovc_d_r;     // overcurrent last cycle
   logic             therm_d_r;   // thermal last cycle
   logic             uvlo_d_r;    // undervoltage last cycle

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovc_d_r   <= 1'b0;
         therm_d_r <= 1'b0;
         uvlo_d_r  <= 1'b0;
      end else begin
         ovc_d_r   <= ovc_s;
         therm_d_r <= therm_s;
         uvlo_d_r  <= uvlo_s;
      end
   end

   always_comb begin
      int_set            = '0;
      int_set[INT_STEP]  = step_rise && pins_s.reset_n;
      int_set[INT_TRIPA] = tripev_a;
      int_set[INT_TRIPB] = tripev_b;
      int_set[INT_OVC]   = ovc_s && !ovc_d_r;
      int_set[INT_THERM] = therm_s && !therm_d_r;
      int_set[INT_UVLO]  = uvlo_s && !uvlo_d_r;
   end

   assign int_clr = (wr_acc && paddr == ADDR_INT_STAT) ? pwdata[INT_W-1:0] : '0;

   // a set in the clearing cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= '0;
      end else begin
         int_stat_r <= (int_stat_r & ~int_clr) | int_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask_r <= '0;
      end else if (wr_acc && paddr == ADDR_INT_MASK) begin
         int_mask_r <= pwdata[INT_W-1:0];
      end
   end

   assign irq = |(int_stat_r & int_mask_r);

   // ==========================================================
   // read data
   // ==========================================================
   logic [31:0] status_w;   // live status word

   always_comb begin
      status_w                     = '0;
      status_w[ST_PHASE +: 3]      = phase_r;
      status_w[ST_GATE_A +: 4]     = gate_a;
      status_w[ST_GATE_B +: 4]     = gate_b;
      status_w[ST_FAULT]           = fault_r;
      status_w[ST_EN]              = bridge_en;
   end

   // sampled in the setup phase, valid throughout the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (rd_setup) begin
         pslverr <= !addr_ok;
         prdata  <= '0;
         if (!pwrite) begin
            unique case (paddr)
               ADDR_STATUS:    prdata <= status_w;
               ADDR_OFFTIME_A: prdata <= 32'(offtime_net_a_r);
               ADDR_OFFTIME_B: prdata <= 32'(offtime_net_b_r);
               ADDR_INT_STAT:  prdata <= 32'(int_stat_r);
               ADDR_INT_MASK:  prdata <= 32'(int_mask_r);
               default:        prdata <= '0;
            endcase
         end
      end
   end

endmodule : spc_top

// [verif/spc_host.sv]
// spc_host: host controller model driving the step and mode pins.
// assumes the bench sets mode levels and calls step and home by hierarchy.
`timescale 1ns/1ps
module spc_host
   import spc_pkg::*;
(
   output spc_pkg::spc_pins_t pins,
   input  wire logic          enable_oe_n
);
   logic stp = 1'b0, dir = 1'b1, half = 1'b1, slow = 1'b0, rst_n = 1'b1, en = 1'b1;
   // open drain: the device pulling low wins over the host level
   assign pins = {stp, dir, half, slow, rst_n, en & enable_oe_n};
   // ===========================================
   // link clock: 64 ns period, still between frames
   task automatic step(input int n);
      repeat (n) begin
         #32 stp = 1'b1;
         #32 stp = 1'b0;
      end
      #1000;
   endtask : step
   task automatic home();
      rst_n = 1'b0;
      #1000 rst_n = 1'b1;
      #1000;
   endtask : home
endmodule : spc_host

// [verif/spc_top_props.sv]
// spc_top_props: port-level checks of spc_top.
// assumes one pclk domain; bound to every spc_top instance.
`timescale 1ns/1ps
module spc_top_props
   import spc_pkg::*;
#(
   parameter int OW = OFF_W
) (
   input logic               pclk,
   input logic               presetn,
   input logic               psel,
   input logic               penable,
   input logic [7:0]         paddr,
   input logic [31:0]        prdata,
   input logic               pready,
   input logic               pslverr,
   input spc_pkg::spc_pins_t pins,
   input logic               enable_oe_n,
   input logic               overcurrent_limit,
   input logic               undervoltage,
   input spc_pkg::spc_gate_t gate_a,
   input spc_pkg::spc_gate_t gate_b
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ===========================================
   // levels held long enough to pass the synchroniser
   sequence s_en_low;
      !pins.enable [*4];
   endsequence
   sequence s_uv_high;
      undervoltage [*4];
   endsequence
   a_shoot_thru: assert property (!(gate_a.hi1 && gate_a.lo1) && !(gate_a.hi2 && gate_a.lo2) &&
      !(gate_b.hi1 && gate_b.lo1) && !(gate_b.hi2 && gate_b.lo2)) else $error("leg shorted");
   a_dead_a: assert property ($fell(gate_a.lo2) |=> !gate_a.hi2 [*8]) else $error("no dead time a");
   a_dead_b: assert property ($fell(gate_b.hi1) |=> !gate_b.lo1 [*8]) else $error("no dead time b");
   a_enable_off: assert property (s_en_low |=> gate_a == '0 && gate_b == '0) else $error("gates on");
   a_uvlo_off: assert property (s_uv_high |=> gate_a == '0 && gate_b == '0) else $error("gates on");
   a_fault_pull: assert property (overcurrent_limit [*4] |-> ##[0:2] !enable_oe_n)
      else $error("enable not pulled");
   a_ready_high: assert property (psel |-> pready) else $error("wait state");
   a_slverr_map: assert property (psel && penable && paddr > 8'h10 |-> pslverr) else $error("no error");
   a_err_zero: assert property (psel && penable && pslverr |-> prdata == 32'h0) else $error("error data");
endmodule : spc_top_props
bind spc_top spc_top_props #(.OW(OW)) u_props (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
   .pslverr, .pins, .enable_oe_n, .overcurrent_limit, .undervoltage, .gate_a, .gate_b);

// [verif/spc_top_test.sv]
// spc_top_test: self-checking bench of spc_top over APB and host pins.
// assumes spc_host drives the logic pins; runs at 200 MHz.
`timescale 1ns/1ps
module spc_top_test;
   import spc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, enable_o, enable_oe_n, irq;
   logic trip_a = 0, trip_b = 0, ovc = 0, therm = 0, uvlo = 0;
   spc_pins_t pins;
   spc_gate_t gate_a, gate_b;
   int errors = 0, samples_checked = 0, cyc = 0, n, ph = 0;
   spc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
      .enable_o(enable_o), .enable_oe_n(enable_oe_n), .sense_trip_a(trip_a), .sense_trip_b(trip_b),
      .overcurrent_limit(ovc), .thermal_fault(therm), .undervoltage(uvlo), .gate_a(gate_a),
      .gate_b(gate_b), .irq(irq));
   spc_host u_host (.pins(pins), .enable_oe_n(enable_oe_n));
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   // ===========================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; r and e take the answer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   // count cycles until gate_a matches v (eq=1) or leaves it (eq=0)
   task automatic wait_a(input logic [3:0] v, input logic eq);
      n = 0;
      while ((gate_a === v) !== eq && n < 2000) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_a
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         $display("FAIL %0t timeout", $time);
         results();
      end
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ADDR_OFFTIME_A, 0); chk(r, 32'h00000a28);
      apb(0, ADDR_INT_MASK, 0); chk(r, 32'h0);
      apb(0, 8'h40, 0); chk(e, 1'b1);
      apb(1, ADDR_OFFTIME_A, 32'd50);
      apb(1, ADDR_OFFTIME_B, 32'd90);
      apb(0, ADDR_OFFTIME_B, 0); chk(r, 32'd90);
      $display("test registers done");
      u_host.home();
      apb(0, ADDR_STATUS, 0); chk(r[2:0], PHASE_HOME);
      // every direction and step size, three edges each
      for (int m = 0; m < 4; m++) begin
         @(posedge pclk);
         u_host.dir <= m[0];
         u_host.half <= m[1];
         u_host.step(3);
         ph = (ph + (m[0] ? 3 : 21) * (m[1] ? 1 : 2)) % 8;
         apb(0, ADDR_STATUS, 0); chk(r[2:0], ph);
      end
      $display("test sequencer done");
      apb(1, ADDR_INT_STAT, 32'h3f);
      apb(1, ADDR_INT_MASK, 32'h1); chk(irq, 1'b0);
      u_host.step(1); chk(irq, 1'b1);
      apb(0, ADDR_STATUS, 0); chk(r[2:0], 3'h1);
      apb(1, ADDR_INT_MASK, 32'h0); chk(irq, 1'b0);
      apb(1, ADDR_INT_MASK, 32'h1); chk(irq, 1'b1);
      apb(1, ADDR_INT_STAT, 32'h1); chk(irq, 1'b0);
      $display("test interrupts done");
      // state 2: both bridges positive; trip held so bridge a chops
      wait_a(4'b1001, 1);
      for (int s = 1; s >= 0; s--) begin
         u_host.slow <= s[0];
         trip_a <= 1'b1;
         wait_a(4'b1001, 0);
         wait_a(4'b1001, 1); chk(n >= 248 && n <= 254, 1'b1);
         wait_a(4'b1001, 0); chk(n >= 498 && n <= 506, 1'b1);
         chk(gate_a, s ? 4'b1000 : 4'b0000);
         chk(gate_b, 4'b1001);
         trip_a <= 1'b0;
         wait_a(4'b1001, 1);
      end
      $display("test chopper done");
      for (int f = 0; f < 2; f++) begin
         {therm, ovc} <= 2'b01 << f;
         repeat (10) @(posedge pclk);
         chk({enable_o, enable_oe_n, gate_a, gate_b}, 10'h0);
         apb(0, ADDR_STATUS, 0); chk(r, 32'h00001001);
         {therm, ovc} <= 2'b00;
         wait_a(4'b1001, 1); chk(n < 2000, 1'b1);
      end
      u_host.en <= 1'b0;
      repeat (10) @(posedge pclk);
      chk({gate_a, gate_b}, 8'h0);
      u_host.en <= 1'b1;
      uvlo <= 1'b1;
      repeat (10) @(posedge pclk);
      chk({gate_a, gate_b}, 8'h0);
      uvlo <= 1'b0;
      apb(0, ADDR_INT_STAT, 0); chk(r, 32'h0000003a);
      $display("test protection done");
      results();
   end
endmodule : spc_top_test
